// ===== inc/wic_pkg.sv
// shared constants for the watchdog and interrupt control block
package wic_pkg;

    // bus shape
    localparam int unsigned ADDR_W = 19;
    localparam int unsigned DATA_W = 32;

    // register indices; the byte address is four times the index
    localparam int unsigned IDX_FLAGS     = 32'h0001FFF0;
    localparam int unsigned IDX_FLAG_CLR  = 32'h0001FFF1;
    localparam int unsigned IDX_INT_CTRL  = 32'h0001FFF6;
    localparam int unsigned IDX_WDOG_CTRL = 32'h0001FFF7;

    localparam logic [ADDR_W-1:0] ADDR_FLAGS     = ADDR_W'(IDX_FLAGS * 4);
    localparam logic [ADDR_W-1:0] ADDR_FLAG_CLR  = ADDR_W'(IDX_FLAG_CLR * 4);
    localparam logic [ADDR_W-1:0] ADDR_INT_CTRL  = ADDR_W'(IDX_INT_CTRL * 4);
    localparam logic [ADDR_W-1:0] ADDR_WDOG_CTRL = ADDR_W'(IDX_WDOG_CTRL * 4);

    // watchdog control fields
    localparam int unsigned WD_STROBE_BIT = 7;
    localparam int unsigned WD_WPROT_BIT  = 6;
    localparam int unsigned WD_PERIOD_W   = 6;

    // interrupt control fields; flags register uses bits 7..5 alike
    localparam int unsigned IE_WDOG_BIT   = 7;
    localparam int unsigned IE_ALARM_BIT  = 6;
    localparam int unsigned IE_PFAIL_BIT  = 5;
    localparam int unsigned IE_ABE_BIT    = 4;
    localparam int unsigned IE_HL_BIT     = 3;
    localparam int unsigned IE_PL_BIT     = 2;

    // reset values
    localparam logic [7:0] INT_CTRL_RST = 8'h00;
    localparam logic [7:0] WDOG_RST     = 8'h00;
    localparam logic [2:0] FLAGS_RST    = 3'h0;

    // timing
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned TICK_HZ     = 32;
    localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;

endpackage

// ===== core/wic_tick_div.sv
// divider that makes the 32 Hz watchdog tick from the system clock
`timescale 1ns/1ps
module wic_tick_div
    import wic_pkg::*;
#(
    parameter int unsigned TICKS = TICK_CYCLES
)
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic restart,
    output logic      tick
);
    localparam int unsigned CW = $clog2(TICKS);

    logic [CW-1:0] cnt_q;

    // a divider of one cycle cannot restart its phase
    if (TICKS < 2)
    begin : g_chk
        $error("wic_tick_div: TICKS must be at least 2");
    end

    // restart aligns the phase so the first tick is one full period away
    always_ff @(posedge clk)
    begin
        if (reset || restart)
            cnt_q <= '0;
        else if (cnt_q == CW'(TICKS - 1))
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + CW'(1);
    end

    // tick registered so it is a clean one-cycle pulse
    always_ff @(posedge clk)
    begin
        if (reset || restart)
            tick <= 1'b0;
        else
            tick <= (cnt_q == CW'(TICKS - 2));
    end
endmodule

// ===== core/wic_wdog_cnt.sv
// six-bit watchdog down counter clocked by the 32 Hz tick
`timescale 1ns/1ps
module wic_wdog_cnt
    import wic_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   load,
    input  wire logic [WD_PERIOD_W-1:0] load_val,
    input  wire logic                   tick,
    output logic      [WD_PERIOD_W-1:0] count,
    output logic                        timeout
);
    // zero means stopped: either never armed, disabled, or expired
    always_ff @(posedge clk)
    begin
        if (reset)
            count <= '0;
        else if (load)
            count <= load_val;
        else if (tick && count != '0)
            count <= count - WD_PERIOD_W'(1);
    end

    // expiry pulse on the tick that takes the count from one to zero
    always_ff @(posedge clk)
    begin
        if (reset)
            timeout <= 1'b0;
        else
            timeout <= !load && tick && (count == WD_PERIOD_W'(1));
    end
endmodule

// ===== core/wic_top.sv
// watchdog and interrupt control block with an Avalon-MM register slave
//
// How it works
// RULE_01 - with write protect set, watchdog writes keep the six period bits
// RULE_02 - with write protect clear, watchdog writes load the period bits
// RULE_03 - watchdog enable on: expiry sets watchdog flag and drives interrupt
// RULE_04 - watchdog enable off: expiry sets the flag only, interrupt stays idle
// RULE_05 - alarm enable on: alarm match sets alarm flag and drives interrupt
// RULE_06 - alarm enable off: alarm match sets only the alarm flag
// RULE_07 - power-fail enable on: power failure sets its flag and drives interrupt
// RULE_08 - power-fail enable off: power failure sets only its flag
// RULE_09 - interrupt control bits one and zero read zero; software writes zero
// RULE_10 - polarity bit one drives pin high-active, zero gives open-drain low-active
// RULE_11 - strobe bit write reloads counter from period; bit reads as zero
// RULE_12 - timeout equals period times 32 Hz tick; reaching zero signals expiry
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module wic_top
    import wic_pkg::*;
#(
    parameter int unsigned TICKS = TICK_CYCLES
)
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [3:0]        byteenable,
    input  wire logic [DATA_W-1:0] writedata,
    output logic      [DATA_W-1:0] readdata,
    output logic                   waitrequest,
    input  wire logic              alarm_match,
    input  wire logic              power_fail,
    output logic                   irq,
    output logic                   int_pin_out,
    output logic                   int_pin_oe,
    output logic                   alarm_backup_enable,
    output logic                   pulse_level_sel
);

    ////////////////////////////////////////////////////////////////////////
    // state

    logic                   served_q;
    logic [DATA_W-1:0]      rdata_q;
    logic                   wprot_q;
    logic [WD_PERIOD_W-1:0] period_q;
    logic [WD_PERIOD_W-1:0] period_d;
    logic [7:0]             ictrl_q;
    logic [2:0]             flags_q;
    logic [2:0]             flags_d;
    logic                   pf_meta_q;
    logic                   pf_sync_q;
    logic                   pf_prev_q;
    logic                   wr_go;
    logic                   rd_go;
    logic                   wr_lane0;
    logic                   wr_wdog;
    logic                   strobe;
    logic                   tick;
    logic                   timeout;
    logic                   pf_event;
    logic [WD_PERIOD_W-1:0] wd_count;
    logic [2:0]             ie_bits;

    // register decode used for both reads and writes
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        hit = (a == r);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // avalon slave handshake

    // one wait state per access; lets read data come out of a flop
    assign waitrequest = (read || write) && !served_q;
    assign wr_go       = write && !waitrequest;
    assign rd_go       = read && !waitrequest;
    assign wr_lane0    = wr_go && byteenable[0];
    assign wr_wdog     = wr_lane0 && hit(address, ADDR_WDOG_CTRL);

    // served toggles high for exactly the completing cycle
    always_ff @(posedge clk)
    begin
        if (reset)
            served_q <= 1'b0;
        else
            served_q <= (read || write) && !served_q;
    end

    // read data captured during the wait cycle, held for the answer
    always_ff @(posedge clk)
    begin
        if (reset)
            rdata_q <= '0;
        else if (read && !served_q)
        begin
            rdata_q <= '0;
            if (hit(address, ADDR_FLAGS))
                rdata_q[7:5] <= flags_q;
            else if (hit(address, ADDR_INT_CTRL))
                // bits one and zero are forced to zero here
                // RULE_09 reserved read zero
                rdata_q[7:2] <= ictrl_q[7:2];
            else if (hit(address, ADDR_WDOG_CTRL))
                // strobe is write-only and never reads back
                // RULE_11 strobe reads zero
                rdata_q[7:0] <= {1'b0, wprot_q, period_q};
        end
    end

    assign readdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // watchdog control register

    // next period: the protect bit in force before this write decides
    always_comb
    begin
        period_d = period_q;
        if (wr_wdog && !wprot_q)
            // RULE_02 unprotected period write
            period_d = writedata[WD_PERIOD_W-1:0];
        // RULE_01 protected period kept
    end

    // protect bit itself is always writable, else it could never be cleared
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wprot_q  <= WDOG_RST[WD_WPROT_BIT];
            period_q <= WDOG_RST[WD_PERIOD_W-1:0];
        end
        else
        begin
            if (wr_wdog)
                wprot_q <= writedata[WD_WPROT_BIT];
            period_q <= period_d;
        end
    end

    // strobe is not stored; it is a pulse that lasts the write cycle
    // RULE_11 strobe reloads counter
    assign strobe = wr_wdog && writedata[WD_STROBE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // watchdog time base and counter

    // tick phase restarts on reload so the period is whole ticks
    // RULE_12 period in ticks
    wic_tick_div #(
        .TICKS    (TICKS)
    ) u_tick (
        .clk      (clk),
        .reset    (reset),
        .restart  (strobe),
        .tick     (tick)
    );

    wic_wdog_cnt u_cnt (
        .clk      (clk),
        .reset    (reset),
        .load     (strobe),
        .load_val (period_d),
        .tick     (tick),
        .count    (wd_count),
        .timeout  (timeout)
    );

    ////////////////////////////////////////////////////////////////////////
    // interrupt control register

    // low two bits are never stored, so they cannot read back nonzero
    always_ff @(posedge clk)
    begin
        if (reset)
            ictrl_q <= INT_CTRL_RST;
        else if (wr_lane0 && hit(address, ADDR_INT_CTRL))
            ictrl_q <= {writedata[7:2], 2'b00};
    end

    assign ie_bits             = ictrl_q[IE_WDOG_BIT:IE_PFAIL_BIT];
    assign alarm_backup_enable = ictrl_q[IE_ABE_BIT];
    assign pulse_level_sel     = ictrl_q[IE_PL_BIT];

    ////////////////////////////////////////////////////////////////////////
    // event capture and sticky flags

    // power fail comes from a pin; two flops before anything looks at it
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pf_meta_q <= 1'b0;
            pf_sync_q <= 1'b0;
            pf_prev_q <= 1'b0;
        end
        else
        begin
            pf_meta_q <= power_fail;
            pf_sync_q <= pf_meta_q;
            pf_prev_q <= pf_sync_q;
        end
    end

    assign pf_event = pf_sync_q && !pf_prev_q;

    // flags set regardless of enables; a set beats a same-cycle clear
    always_comb
    begin
        flags_d = flags_q;
        if (wr_lane0 && hit(address, ADDR_FLAG_CLR))
            flags_d = flags_q & ~writedata[7:5];
        // RULE_03 RULE_04 watchdog flag set
        if (timeout)
            flags_d[2] = 1'b1;
        // RULE_05 RULE_06 alarm flag set
        if (alarm_match)
            flags_d[1] = 1'b1;
        // RULE_07 RULE_08 power-fail flag set
        if (pf_event)
            flags_d[0] = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            flags_q <= FLAGS_RST;
        else
            flags_q <= flags_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt output and pin drive

    // only enabled flags reach the line; disabled ones stay silent
    // RULE_03 RULE_04 RULE_05 RULE_06 RULE_07 RULE_08 enable gating
    assign irq = |(flags_q & ie_bits);

    // open-drain mode only ever pulls low, never drives high
    // RULE_10 pin polarity select
    assign int_pin_out = ictrl_q[IE_HL_BIT] ? irq : 1'b0;
    assign int_pin_oe  = ictrl_q[IE_HL_BIT] ? 1'b1 : irq;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_WPROT_KEEPS_PERIOD: assert property ( // RULE_01
        (wr_wdog && wprot_q) |=> (period_q == $past(period_q)))
        else $error("protected period changed");

    AST_PERIOD_WRITTEN: assert property ( // RULE_02
        (wr_wdog && !wprot_q) |=> (period_q == $past(writedata[WD_PERIOD_W-1:0])))
        else $error("period not written");

    AST_WDOG_IRQ: assert property ( // RULE_03
        (timeout && ie_bits[2]) |=> (flags_q[2] && irq))
        else $error("watchdog expiry did not raise irq");

    AST_WDOG_QUIET: assert property ( // RULE_04
        (timeout && !ie_bits[2] && !(|(flags_d[1:0] & ie_bits[1:0])) && !wr_lane0)
        |=> (flags_q[2] && !irq))
        else $error("disabled watchdog drove irq");

    AST_ALARM_IRQ: assert property ( // RULE_05
        (alarm_match && ie_bits[1]) |=> (flags_q[1] && irq))
        else $error("alarm did not raise irq");

    AST_ALARM_QUIET: assert property ( // RULE_06
        (flags_q[1] && !ie_bits[1] && !(|(flags_q[2] & ie_bits[2]))
         && !(|(flags_q[0] & ie_bits[0]))) |-> !irq)
        else $error("disabled alarm drove irq");

    AST_PFAIL_IRQ: assert property ( // RULE_07
        ($rose(pf_sync_q) && ie_bits[0]) |=> (flags_q[0] && irq))
        else $error("power fail did not raise irq");

    AST_PFAIL_QUIET: assert property ( // RULE_08
        (flags_q[0] && !ie_bits[0] && !(|(flags_q[2:1] & ie_bits[2:1]))) |-> !irq)
        else $error("disabled power fail drove irq");

    AST_RSVD_ZERO: assert property ( // RULE_09
        (rd_go && hit(address, ADDR_INT_CTRL)) |-> (readdata[1:0] == 2'b00))
        else $error("reserved bits read nonzero");

    AST_PIN_MODE: assert property ( // RULE_10
        ictrl_q[IE_HL_BIT] ? (int_pin_oe && int_pin_out == irq)
                           : (!int_pin_out && int_pin_oe == irq))
        else $error("interrupt pin drive wrong");

    AST_STROBE_RELOAD: assert property ( // RULE_11
        strobe |=> (wd_count == period_q) ##1 (wd_count == period_q))
        else $error("strobe did not reload counter");

    AST_TIMEOUT_AT_ONE: assert property ( // RULE_12
        timeout |-> (wd_count == '0) && ($past(wd_count) == WD_PERIOD_W'(1)))
        else $error("timeout not at count one to zero");

    AST_STROBE_READS_ZERO: assert property ( // RULE_11
        (rd_go && hit(address, ADDR_WDOG_CTRL)) |-> !readdata[WD_STROBE_BIT])
        else $error("strobe bit read back");

    COV_WDOG_TIMEOUT: cover property (strobe ##[1:1000] timeout);
    COV_ALARM_IRQ:    cover property (alarm_match && ie_bits[1] ##1 irq);
    COV_PFAIL_IRQ:    cover property ($rose(pf_sync_q) && ie_bits[0] ##1 irq);
    COV_OPEN_DRAIN:   cover property (irq && !ictrl_q[IE_HL_BIT] && int_pin_oe);

endmodule

// ===== bench/wic_evt_src.sv
// event sources beside the block and the resolved interrupt wire
`timescale 1ns/1ps
module wic_evt_src
(
    input  wire logic clk,
    output logic      alarm_match,
    output logic      power_fail,
    input  wire logic int_pin_out,
    input  wire logic int_pin_oe,
    output logic      int_wire
);
    ////////////////////////////////////////////////////////////////////////////////
    // wire with a pull-up: released pin floats high, never shows the last driven value
    assign int_wire = int_pin_oe ? int_pin_out : 1'b1;

    // idle sources at time zero
    initial
    begin
        alarm_match = 1'b0;
        power_fail  = 1'b0;
    end

    // single-cycle match from same-clock comparator logic
    task automatic pulse_alarm();
        @(posedge clk);
        alarm_match <= 1'b1;
        @(posedge clk);
        alarm_match <= 1'b0;
    endtask

    // supply monitor level, changes only after an edge
    task automatic set_fail(input logic v);
        @(posedge clk);
        power_fail <= v;
    endtask
endmodule

// ===== bench/watchdog_and_interrupt_control_test.sv
// self-checking bench for the watchdog and interrupt control block
`timescale 1ns/1ps
module watchdog_and_interrupt_control_test
    import wic_pkg::*;
;
    localparam int TK = 8; // short tick keeps watchdog runs to a few dozen cycles
    logic              clk;
    logic              reset;
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [3:0]        byteenable;
    logic [DATA_W-1:0] writedata;
    logic [DATA_W-1:0] readdata;
    logic              waitrequest;
    logic              alarm_match;
    logic              power_fail;
    logic              irq;
    logic              int_pin_out;
    logic              int_pin_oe;
    logic              int_wire;
    logic              alarm_backup_enable;
    logic              pulse_level_sel;
    logic [31:0]       seed;
    int                miscompares;
    int                n_compared;
    int                cycles;
    logic [7:0]        v;
    logic [5:0]        p;

    ////////////////////////////////////////////////////////////////////////////////
    wic_top #(.TICKS(TK)) u_dut (.clk(clk), .reset(reset), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .alarm_match(alarm_match), .power_fail(power_fail),
        .irq(irq), .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe),
        .alarm_backup_enable(alarm_backup_enable), .pulse_level_sel(pulse_level_sel));
    wic_evt_src u_src (.clk(clk), .alarm_match(alarm_match), .power_fail(power_fail),
        .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .int_wire(int_wire));

    // 100 ns clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // hang guard: whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 5000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one Avalon access; request held until waitrequest is seen low, released after the edge
    // read data does not move at the completing edge, so it is taken right at that edge;
    // the task returns mid-cycle so callers look at outputs that have settled
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk);
        address   <= a;
        writedata <= {24'h000000, d};
        write     <= wr;
        read      <= !wr;
        @(negedge clk);
        while (waitrequest !== 1'b0)
            @(negedge clk);
        @(posedge clk);
        q = readdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
        @(negedge clk);
    endtask

    task automatic wreg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk_reg(q, exp);
    endtask

    task automatic wrap_up();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'h0000308F;
        miscompares = 0;
        n_compared = 0;
        cycles = 0;
        reset = 1'b1;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'hF;
        writedata = '0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        // reset values, plus an unmapped read that must come back empty
        rchk(ADDR_INT_CTRL, INT_CTRL_RST);
        rchk(ADDR_WDOG_CTRL, WDOG_RST);
        rchk(ADDR_FLAGS, 8'h00);
        rchk(19'h00010, 8'h00);
        $display("test reset_values done");
        // random control values; software keeps the reserved pair at zero
        for (int i = 0; i < 6; i++)
        begin
            v = 8'(xs()) & 8'hFC;
            wreg(ADDR_INT_CTRL, v);
            rchk(ADDR_INT_CTRL, v & 8'hFC);
            chk_bit(alarm_backup_enable, v[4]);
            chk_bit(pulse_level_sel, v[2]);
        end
        // lane zero disabled: the write must be ignored
        @(posedge clk);
        byteenable <= 4'hE;
        wreg(ADDR_INT_CTRL, ~v & 8'hFC);
        rchk(ADDR_INT_CTRL, v);
        @(posedge clk);
        byteenable <= 4'hF;
        $display("test int_ctrl done");
        // period writes open and under protect; strobe never reads back
        for (int i = 0; i < 6; i++)
        begin
            p = 6'(xs());
            wreg(ADDR_WDOG_CTRL, {2'b00, p});
            rchk(ADDR_WDOG_CTRL, {2'b00, p});
            // the protect bit held before a write decides, so arm it first
            wreg(ADDR_WDOG_CTRL, {2'b01, p});
            rchk(ADDR_WDOG_CTRL, {2'b01, p});
            wreg(ADDR_WDOG_CTRL, {2'b11, ~p});
            rchk(ADDR_WDOG_CTRL, {2'b01, p});
            wreg(ADDR_WDOG_CTRL, 8'h00);
            rchk(ADDR_WDOG_CTRL, {2'b00, p});
        end
        wreg(ADDR_WDOG_CTRL, 8'h80);
        $display("test period_protect done");
        // expiry with the watchdog enable off, then on
        for (int en = 0; en < 2; en++)
        begin
            wreg(ADDR_INT_CTRL, {en[0], 7'h08});
            wreg(ADDR_FLAG_CLR, 8'hE0);
            p = 6'(2 + en);
            wreg(ADDR_WDOG_CTRL, {2'b10, p});
            repeat (int'(p) * TK - 5) @(posedge clk);
            rchk(ADDR_FLAGS, 8'h00);
            repeat (6) @(posedge clk);
            rchk(ADDR_FLAGS, 8'h80);
            chk_bit(irq, en[0]);
            chk_bit(int_wire, en[0]);
            wreg(ADDR_WDOG_CTRL, 8'h80);
        end
        $display("test watchdog_expiry done");
        // alarm match with enable off, then on
        for (int en = 0; en < 2; en++)
        begin
            wreg(ADDR_INT_CTRL, {1'b0, en[0], 6'h08});
            wreg(ADDR_FLAG_CLR, 8'hE0);
            u_src.pulse_alarm();
            rchk(ADDR_FLAGS, 8'h40);
            chk_bit(irq, en[0]);
        end
        $display("test alarm done");
        // power failure with enable off, then on; open-drain pin checked while it is pending
        for (int en = 0; en < 2; en++)
        begin
            wreg(ADDR_INT_CTRL, {2'b00, en[0], 5'h08});
            wreg(ADDR_FLAG_CLR, 8'hE0);
            u_src.set_fail(1'b1);
            repeat (5) @(posedge clk);
            rchk(ADDR_FLAGS, 8'h20);
            chk_bit(irq, en[0]);
            wreg(ADDR_INT_CTRL, {2'b00, en[0], 5'h00});
            chk_bit(int_wire, !en[0]);
            chk_bit(int_pin_oe, en[0]);
            wreg(ADDR_FLAG_CLR, 8'hE0);
            chk_bit(int_wire, 1'b1);
            u_src.set_fail(1'b0);
        end
        $display("test power_fail done");
        wrap_up();
    end
endmodule
